//--- rtl/stp_pkg.sv
`default_nettype none
package stp_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_SAFE = 8'h08;
  localparam logic [7:0] REG_THRESH = 8'h0C;
  localparam logic [7:0] REG_GOAL = 8'h10;
  localparam logic [7:0] REG_ACTUAL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHAFT_BIT = 2;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_OP_LSB = 16;
  localparam int ST_MOVING_BIT = 0;
  localparam int ST_DIR_BIT = 1;
  localparam int ST_STALL_BIT = 2;
  localparam int ST_SAFE_OFF_BIT = 3;
  localparam int COIL_PHASE_BIT = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic SHAFT_RST = 1'b0;
  localparam logic [10:0] SAFE_RST = 11'h400;
  localparam logic [7:0] THRESH_RST = 8'h10;
  localparam logic [15:0] POS_RST = 16'h0000;
  // ****************************************
  // Stepping modes and commands
  // ****************************************
  localparam logic [1:0] MODE_HALF = 2'h0;
  localparam logic [1:0] MODE_QUARTER = 2'h1;
  localparam logic [1:0] MODE_EIGHTH = 2'h2;
  localparam logic [1:0] MODE_SIXTEENTH = 2'h3;
  localparam logic [2:0] OP_FULL = 3'h1;
  localparam logic [2:0] OP_COMPACT = 3'h2;
  localparam logic [2:0] OP_SAFE_GO = 3'h3;
  localparam logic [2:0] OP_TWO_PHASE = 3'h4;
  localparam logic [2:0] OP_LOST_LINK = 3'h5;
  localparam logic [10:0] SAFE_DISABLE_CODE = 11'h400;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_PERIOD_NS = 10000;
  localparam int STEP_CYCLES = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] STEP_LAST = 10'(STEP_CYCLES - 1);
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [2:0] op;
    logic [15:0] data;
  } stp_cmd_t;
  typedef struct packed {
    logic safe_off;
    logic stalled;
    logic dir;
    logic moving;
  } stp_status_t;
  typedef enum logic {ST_IDLE, ST_RUN} stp_state_t;
endpackage
`default_nettype wire

//--- rtl/stp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module stp_sync
  import stp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage;
  // The output only moves once the last two stages agree
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async_in};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync_out <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      sync_out <= stage[2];
    end
  end
endmodule
`default_nettype wire

//--- rtl/stp_align.sv
`timescale 1ns/100ps
`default_nettype none
module stp_align
  import stp_pkg::*;
(
  input wire stp_cmd_t cmd,
  input wire logic [1:0] step_mode,
  input wire logic [10:0] safe_point_value,
  output logic [15:0] aligned_word
);
  // All words come out in sixteenth-step units, two's complement
  always_comb begin
    aligned_word = POS_RST;
    case (cmd.op)
      OP_FULL: begin
        case (step_mode)
          MODE_HALF: aligned_word = {cmd.data[12:0], 3'h0};
          MODE_QUARTER: aligned_word = {cmd.data[13:0], 2'h0};
          MODE_EIGHTH: aligned_word = {cmd.data[14:0], 1'h0};
          default: aligned_word = cmd.data;
        endcase
      end
      OP_COMPACT: aligned_word = {{2{cmd.data[10]}}, cmd.data[10:0], 3'h0};
      OP_SAFE_GO, OP_TWO_PHASE, OP_LOST_LINK: begin
        aligned_word = {safe_point_value, 5'h00};
      end
      default: aligned_word = POS_RST;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/stp_pos_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module stp_pos_decoder
  import stp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic otp_valid,
  input wire logic [10:0] otp_safe_point,
  input wire logic otp_shaft,
  input wire logic [7:0] bemf_sample,
  output logic coil_x_plus,
  output logic coil_x_minus,
  output logic step_pulse,
  output logic step_dir,
  output logic motor_running
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0] step_mode;
  logic shaft;
  logic [10:0] safe_point_value;
  logic [7:0] bemf_threshold;
  logic [15:0] goal_position;
  logic [15:0] actual_position;
  logic stalled;
  logic otp_ready;
  logic otp_loaded;
  logic started;
  logic [9:0] step_cnt;
  logic step_tick;
  stp_state_t state;
  stp_cmd_t cmd_in;
  stp_status_t status;
  logic [15:0] aligned_word;
  logic [15:0] diff;
  logic safe_off;
  logic access;
  logic wr_en;
  logic mapped;
  logic cmd_fire;
  logic stall_now;
  logic [15:0] next_actual;

  // ****************************************
  // Submodules
  // ****************************************
  stp_sync u_otp_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(otp_valid),
    .sync_out(otp_ready)
  );

  assign cmd_in = stp_cmd_t'({pwdata[CMD_OP_LSB +: 3], pwdata[CMD_DATA_LSB +: 16]});

  stp_align u_align (
    .cmd(cmd_in),
    .step_mode(step_mode),
    .safe_point_value(safe_point_value),
    .aligned_word(aligned_word)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  // One wait state: pready rises one cycle into the access phase
  assign access = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign cmd_fire = wr_en && (paddr == REG_CMD);
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_SAFE) ||
                  (paddr == REG_THRESH) || (paddr == REG_GOAL) ||
                  (paddr == REG_ACTUAL) || (paddr == REG_STATUS);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
    end
  end

  assign status = '{safe_off: safe_off, stalled: stalled, dir: diff[15], moving: state == ST_RUN};

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (access && !pwrite) begin
      if (paddr == REG_CTRL) begin
        prdata <= {29'h0, shaft, step_mode};
      end else if (paddr == REG_SAFE) begin
        prdata <= {21'h0, safe_point_value};
      end else if (paddr == REG_THRESH) begin
        prdata <= {24'h0, bemf_threshold};
      end else if (paddr == REG_GOAL) begin
        prdata <= {{16{goal_position[15]}}, goal_position};
      end else if (paddr == REG_ACTUAL) begin
        prdata <= {{16{actual_position[15]}}, actual_position};
      end else if (paddr == REG_STATUS) begin
        prdata <= {28'h0, status};
      end else begin
        prdata <= 32'h00000000;
      end
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // ****************************************
  // Parameters and start-up load
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      step_mode <= MODE_RST;
      shaft <= SHAFT_RST;
      safe_point_value <= SAFE_RST;
      bemf_threshold <= THRESH_RST;
      otp_loaded <= 1'b0;
    end else if (otp_ready && !otp_loaded) begin
      // Nine bits survive the copy; the two low bits start cleared
      safe_point_value <= {otp_safe_point[10:2], 2'h0};
      shaft <= otp_shaft;
      otp_loaded <= 1'b1;
    end else if (wr_en) begin
      if (paddr == REG_CTRL) begin
        step_mode <= pwdata[CTRL_MODE_LSB +: 2];
        shaft <= pwdata[CTRL_SHAFT_BIT];
      end else if (paddr == REG_SAFE) begin
        safe_point_value <= pwdata[10:0];
      end else if (paddr == REG_THRESH) begin
        bemf_threshold <= pwdata[7:0];
      end
    end
  end

  assign safe_off = (safe_point_value == SAFE_DISABLE_CODE);

  // ****************************************
  // Step rate divider
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      step_cnt <= 10'h000;
      step_tick <= 1'b0;
    end else if (step_cnt == STEP_LAST) begin
      step_cnt <= 10'h000;
      step_tick <= 1'b1;
    end else begin
      step_cnt <= step_cnt + 10'h001;
      step_tick <= 1'b0;
    end
  end

  // ****************************************
  // Motion
  // ****************************************
  // Wrapped difference: the circle has no end, so its sign is the short way
  assign diff = goal_position - actual_position;
  // Back-emf is meaningless before the first step, so the check waits for it
  assign stall_now = started && (bemf_sample < bemf_threshold);
  assign next_actual = diff[15] ? actual_position - 16'h0001 : actual_position + 16'h0001;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      goal_position <= POS_RST;
      actual_position <= POS_RST;
      state <= ST_IDLE;
      started <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          started <= 1'b0;
          if (diff != 16'h0000) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (diff == 16'h0000) begin
            state <= ST_IDLE;
          end else if (step_tick && stall_now) begin
            goal_position <= actual_position;
            state <= ST_IDLE;
          end else if (step_tick) begin
            actual_position <= next_actual;
            started <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // A fresh command overrides a stop taken in the same cycle, except lost link with the safe point disabled, which leaves the stop's goal
      if (cmd_fire) begin
        case (cmd_in.op)
          OP_FULL, OP_COMPACT: goal_position <= aligned_word;
          OP_SAFE_GO: goal_position <= aligned_word;
          OP_TWO_PHASE: goal_position <= safe_off ? POS_RST : aligned_word;
          OP_LOST_LINK: begin
            if (!safe_off) begin
              goal_position <= aligned_word;
            end
          end
          default: goal_position <= goal_position;
        endcase
      end
    end
  end

  // Sticky stall flag, write one to clear; a new stall wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stalled <= 1'b0;
    end else if (state == ST_RUN && diff != 16'h0000 && step_tick && stall_now) begin
      stalled <= 1'b1;
    end else if (wr_en && paddr == REG_STATUS && pwdata[ST_STALL_BIT]) begin
      stalled <= 1'b0;
    end
  end

  // ****************************************
  // Outputs to the driver
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      coil_x_plus <= 1'b1;
      coil_x_minus <= 1'b0;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
      motor_running <= 1'b0;
    end else begin
      coil_x_plus <= ~actual_position[COIL_PHASE_BIT] ^ shaft;
      coil_x_minus <= actual_position[COIL_PHASE_BIT] ^ shaft;
      step_pulse <= step_tick && state == ST_RUN && diff != 16'h0000 && !stall_now;
      step_dir <= diff[15];
      motor_running <= state == ST_RUN;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_pready_single: assert property (@(posedge sys_clk) disable iff (!resetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!resetn)
    access && !mapped |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");
  a_full_half_shift: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmd_fire && cmd_in.op == OP_FULL && step_mode == MODE_HALF
    |=> goal_position == {$past(pwdata[12:0]), 3'h0})
    else $error("half-step full target misaligned");
  a_full_eighth_shift: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmd_fire && cmd_in.op == OP_FULL && step_mode == MODE_EIGHTH
    |=> goal_position == {$past(pwdata[14:0]), 1'h0})
    else $error("eighth-step full target misaligned");
  a_compact_extend: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmd_fire && cmd_in.op == OP_COMPACT
    |=> goal_position == {{2{$past(pwdata[10])}}, $past(pwdata[10:0]), 3'h0})
    else $error("compact target not sign-extended");
  a_safe_go_always: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmd_fire && cmd_in.op == OP_SAFE_GO
    |=> goal_position == {$past(safe_point_value), 5'h00})
    else $error("go-to-safe command not executed");
  a_lost_link_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmd_fire && cmd_in.op == OP_LOST_LINK && safe_off && state == ST_IDLE
    |=> $stable(goal_position))
    else $error("disabled safe point used on lost link");
  a_otp_low_bits: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(otp_loaded) |-> safe_point_value[1:0] == 2'h0)
    else $error("start-up safe point low bits not cleared");
  a_step_direction: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == ST_RUN && diff != 16'h0000 && step_tick && !stall_now && !cmd_fire
    |=> actual_position == ($past(diff[15]) ? $past(actual_position) - 16'h0001
                                            : $past(actual_position) + 16'h0001))
    else $error("step taken the long way round");
  a_stall_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == ST_RUN && diff != 16'h0000 && step_tick && stall_now && !cmd_fire
    |=> state == ST_IDLE && stalled ##1 !motor_running)
    else $error("stall did not stop the motor");
  a_coil_polarity: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 coil_x_plus == ($past(~actual_position[COIL_PHASE_BIT]) ^ $past(shaft)) &&
    coil_x_minus != coil_x_plus)
    else $error("X coil polarity wrong for shaft setting");
endmodule
`default_nettype wire

//--- verif/stp_apb_master.sv
`timescale 1ns/100ps
`default_nettype none
module stp_apb_master (
  input wire logic sys_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // ****************************************
  // Bus master on the far side
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Idle data is inverted so a late sample never sees the old word
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    e = pslverr;
    ok = (n < 100);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- verif/stepper_position_word_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
module stepper_position_word_decoder_test;
  import stp_pkg::*;
  // ****************************************
  // Clock, reset and wiring
  // ****************************************
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, otp_valid, otp_shaft;
  logic coil_x_plus, coil_x_minus, step_pulse, step_dir, motor_running;
  logic [7:0] paddr, bemf_sample;
  logic [31:0] pwdata, prdata;
  logic [10:0] otp_safe_point;
  int err_count, total_checks;
  int steps = 0;
  stp_pos_decoder u_stp_pos_decoder (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .otp_valid(otp_valid),
    .otp_safe_point(otp_safe_point), .otp_shaft(otp_shaft), .bemf_sample(bemf_sample),
    .coil_x_plus(coil_x_plus), .coil_x_minus(coil_x_minus), .step_pulse(step_pulse),
    .step_dir(step_dir), .motor_running(motor_running));
  stp_apb_master u_stp_apb_master (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (step_pulse === 1'b1) begin
      steps <= steps + 1;
    end
  end
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    logic ok;
    u_stp_apb_master.xfer(w, a, d, r, e, ok);
    if (!ok) begin
      $display("unexpected at %0t: bus hang", $time);
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err = 1'b0);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h00000000, r, e);
    chk({e, r}, {exp_err, exp});
  endtask
  task automatic cmd(input logic [2:0] op, input logic [15:0] d);
    wr(REG_CMD, {13'h0000, op, d});
  endtask
  // Stall and normal arrival both end with motor_running low
  task automatic wait_idle();
    int n;
    for (n = 0; n < 6000; n++) begin
      @(posedge sys_clk);
      if (n > 3 && motor_running === 1'b0) begin
        return;
      end
    end
    $display("unexpected at %0t: motion hang", $time);
    err_count++;
    report_and_stop();
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_count = 0;
    total_checks = 0;
    resetn = 1'b0;
    otp_valid = 1'b0;
    otp_shaft = 1'b0;
    otp_safe_point = 11'h000;
    bemf_sample = 8'hFF;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(REG_CTRL, 32'h00000000);
    rd(REG_SAFE, 32'h00000400);
    rd(REG_THRESH, 32'h00000010);
    rd(REG_STATUS, 32'h00000008);
    rd(REG_CMD, 32'h00000000);
    rd(8'h1C, 32'h00000000, 1'b1);
    // Fallback with the safe point disabled, motor at rest: goal must not move
    cmd(OP_LOST_LINK, 16'h0000);
    rd(REG_GOAL, 32'h00000000);
    chk({31'h0, coil_x_plus, coil_x_minus}, 33'h2);
    wr(REG_CTRL, 32'h00000003);
    cmd(OP_FULL, 16'h0002);
    wait_idle();
    chk(33'(steps), 33'h2);
    rd(REG_ACTUAL, 32'h00000002);
    cmd(OP_FULL, 16'h8003);
    repeat (4) @(posedge sys_clk);
    chk({32'h0, step_dir}, 33'h1);
    // Goal just past the most negative code: a plain signed compare goes the long way
    cmd(OP_FULL, 16'h8001);
    repeat (4) @(posedge sys_clk);
    chk({32'h0, step_dir}, 33'h0);
    cmd(OP_FULL, 16'h0002);
    wait_idle();
    for (int m = 0; m < 4; m++) begin
      wr(REG_CTRL, 32'(m));
      cmd(OP_FULL, 16'hFFFF);
      rd(REG_GOAL, 32'hFFFFFFFF << (3 - m));
    end
    cmd(OP_FULL, 16'h7FFF);
    rd(REG_GOAL, 32'h00007FFF);
    wr(REG_CTRL, 32'h00000000);
    cmd(OP_FULL, 16'h0FFF);
    rd(REG_GOAL, 32'h00007FF8);
    cmd(OP_COMPACT, {5'h00, 11'h400});
    rd(REG_GOAL, 32'hFFFFE000);
    cmd(OP_COMPACT, {5'h00, 11'h3FF});
    rd(REG_GOAL, 32'h00001FF8);
    cmd(OP_LOST_LINK, 16'h0000);
    rd(REG_GOAL, 32'h00001FF8);
    cmd(OP_TWO_PHASE, 16'h0000);
    rd(REG_GOAL, 32'h00000000);
    cmd(OP_SAFE_GO, 16'h0000);
    rd(REG_GOAL, 32'hFFFF8000);
    cmd(3'h6, 16'h0123);
    rd(REG_GOAL, 32'hFFFF8000);
    wr(REG_SAFE, 32'h00000123);
    cmd(OP_LOST_LINK, 16'h0000);
    rd(REG_GOAL, 32'h00002460);
    cmd(OP_COMPACT, 16'h0000);
    cmd(OP_TWO_PHASE, 16'h0000);
    rd(REG_GOAL, 32'h00002460);
    cmd(OP_COMPACT, 16'h0000);
    wait_idle();
    rd(REG_ACTUAL, 32'h00000000);
    otp_safe_point <= 11'h7FF;
    otp_shaft <= 1'b1;
    otp_valid <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(REG_SAFE, 32'h000007FC);
    chk({31'h0, coil_x_plus, coil_x_minus}, 33'h1);
    wr(REG_CTRL, 32'h00000003);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, coil_x_plus, coil_x_minus}, 33'h2);
    wr(REG_THRESH, 32'h00000080);
    bemf_sample <= 8'h00;
    cmd(OP_FULL, 16'h0100);
    wait_idle();
    rd(REG_STATUS, 32'h00000004);
    rd(REG_ACTUAL, 32'h00000001);
    rd(REG_GOAL, 32'h00000001);
    wr(REG_STATUS, 32'h00000004);
    rd(REG_STATUS, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
